// File: rtl/i2c_seq_pkg.sv
// constants, register map and state encoding of the two-wire master sequencer
// Contract
// - addressed format: first frame after start is eight bits plus acknowledge
// - serial format: data frames carry no acknowledge slot
// - start: sda falls from high to low while scl stays high
// - direction bit after address: 1 slave to master, 0 master to slave
// - the receiving party drives sda low in the acknowledge slot
// - data bits per frame come from the three-bit count field
// - first-bit-order setting picks msb-first or lsb-first shifting
// - stop: sda rises from low to high while scl stays high
// - master select and transmit direction both 1 give master transmit
// - control write with busy 1 and qualifier 0 makes a start; the code also needs master select and transmit 1
// - start sets done and ready flags; interrupt if enabled
// - format select 0: first frame is 7-bit address plus direction
// - done flag set at the rising edge of the ninth clock
// - scl held low after a frame until next data write starts one
// - received acknowledge bit stored; 1 means no acknowledge
// - writing 0 to acknowledge-check enable clears stored acknowledge
// - control write with busy 0 and qualifier 0 makes a stop
// - master reception: address sent first, then receive with clock and acks
// - moving holding byte into shift register sets empty flag; start too
package i2c_seq_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  // bus_control_register fields
  localparam int C_MST = 0;
  localparam int C_TRS = 1;
  localparam int C_BUSY = 2;
  localparam int C_QUAL = 3;
  localparam int C_IE = 4;
  localparam int C_ACK_CHECK_ENABLE = 5;
  // bus_status_register fields
  localparam int S_DONE = 0;
  localparam int S_RDY = 1;
  localparam int S_ACK = 2;
  localparam int S_EMPTY = 3;
  // bus_mode_register fields
  localparam int M_ORDER = 3;
  localparam int M_FMT = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] FIRST_FRAME_BITS = 4'h9;
  localparam logic [3:0] FULL_BYTE_BITS = 4'h8;
  // timing: scl period split in four quarters
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_HOLD = 3'h3,
    ST_BIT = 3'h2,
    ST_STOP = 3'h6
  } seq_state_t;
endpackage

// File: rtl/bus_line_if.sv
// synchronised bus line levels and detected conditions
`timescale 1ns/1ps
`default_nettype none
interface bus_line_if;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  modport mon (output scl_s, output sda_s, output start_det, output stop_det);
  modport core (input scl_s, input sda_s, input start_det, input stop_det);
endinterface
`default_nettype wire

// File: rtl/line_monitor.sv
// pin synchroniser and start/stop detector for the two bus lines
`timescale 1ns/1ps
`default_nettype none
module line_monitor
  import i2c_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_i,
  input wire logic sda_i,
  bus_line_if.mon lm
);
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic scl_d_q;
  logic sda_d_q;

  // two flops per pin; idle bus level is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
    end
  end

  // third stage only for edge detection, never on the first flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_sy_q[1];
      sda_d_q <= sda_sy_q[1];
    end
  end

  assign lm.scl_s = scl_sy_q[1];
  assign lm.sda_s = sda_sy_q[1];
  // sda edge while scl high on both samples
  assign lm.start_det = scl_sy_q[1] & scl_d_q & sda_d_q & ~sda_sy_q[1];
  assign lm.stop_det = scl_sy_q[1] & scl_d_q & ~sda_d_q & sda_sy_q[1];
endmodule
`default_nettype wire

// File: rtl/i2c_master_transmit_sequencer.sv
// apb-controlled two-wire bus master: start, stop, address and data frames
`timescale 1ns/1ps
`default_nettype none
module i2c_master_transmit_sequencer
  import i2c_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq_req
);
  bus_line_if lm_if();
  seq_state_t st_q;
  logic [1:0] ph_q;
  logic [3:0] bits_left_q;
  logic [7:0] div_q;
  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] hold_q;
  logic [7:0] shift_q;
  logic [31:0] prdata_q;
  logic done_q, rdy_q, rack_q, empty_q, bbusy_q, full_q, rxgo_q;
  logic start_pend_q, stop_pend_q, first_q, with_ack_q, rx_q;
  logic scl_low_q, sda_low_q;
  logic acc, wr, rd, mapped;
  logic tick, frame_go, start_gen, sample, last, ack_slot, out_bit, fmt_serial;
  logic [3:0] bc;

  line_monitor u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .lm(lm_if)
  );

  // apb decode; zero wait states
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_STAT) | (paddr == ADDR_MODE) | (paddr == ADDR_DATA);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // sequencer helpers
  assign tick = (div_q == QUARTER_LAST);
  assign fmt_serial = mode_q[M_FMT];
  assign bc = (mode_q[2:0] == 3'h0) ? FULL_BYTE_BITS : {1'b0, mode_q[2:0]};
  assign last = (bits_left_q == 4'h1);
  assign ack_slot = with_ack_q & last;
  assign out_bit = mode_q[M_ORDER] ? shift_q[0] : shift_q[7];
  assign sample = (st_q == ST_BIT) && (ph_q == 2'h2) && tick && lm_if.scl_s;
  assign start_gen = (st_q == ST_START) && (ph_q == 2'h0) && tick;
  // next frame leaves the hold state only on a quarter tick
  assign frame_go = (st_q == ST_HOLD) && tick && !stop_pend_q &&
                    ((full_q && ctrl_q[C_TRS]) || (rxgo_q && !ctrl_q[C_TRS]));

  // open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
  assign irq_req = done_q & ctrl_q[C_IE];

  // free-running quarter-period divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: prdata_q <= {24'h00_0000, 2'h0, ctrl_q[C_ACK_CHECK_ENABLE], ctrl_q[C_IE], 1'b0, bbusy_q, ctrl_q[1:0]};
        ADDR_STAT: prdata_q <= {28'h000_0000, empty_q, rack_q, rdy_q, done_q};
        ADDR_MODE: prdata_q <= {27'h000_0000, mode_q[4:0]};
        ADDR_DATA: prdata_q <= {24'h00_0000, shift_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // software-owned control, mode and holding registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      mode_q <= MODE_RST;
      hold_q <= 8'h00;
    end else if (wr) begin
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata[7:0];
      if (paddr == ADDR_MODE) mode_q <= pwdata[7:0]; // changing it mid-frame changes the bit order, not the count
      if (paddr == ADDR_DATA) hold_q <= pwdata[7:0];
    end
  end

  // start requests wait for the next quarter tick in idle, stop requests for the next one in the hold state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_CTRL && pwdata[C_BUSY] && !pwdata[C_QUAL] && pwdata[C_MST] && pwdata[C_TRS]) begin
        start_pend_q <= 1'b1;
      end else if (st_q != ST_IDLE) begin
        start_pend_q <= 1'b0;
      end
      if (wr && paddr == ADDR_CTRL && !pwdata[C_BUSY] && !pwdata[C_QUAL] && st_q != ST_IDLE) begin
        stop_pend_q <= 1'b1;
      end else if (st_q == ST_STOP || st_q == ST_IDLE) begin
        stop_pend_q <= 1'b0;
      end
    end
  end

  // data-register side effects: write fills holding, read in receive mode asks for a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
      rxgo_q <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_DATA) full_q <= 1'b1;
      else if (frame_go && ctrl_q[C_TRS]) full_q <= 1'b0;
      if (rd && paddr == ADDR_DATA && !ctrl_q[C_TRS]) rxgo_q <= 1'b1;
      else if (frame_go) rxgo_q <= 1'b0;
    end
  end

  // status flags; a hardware set always wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      rdy_q <= 1'b0;
    end else if (start_gen || (sample && last)) begin
      done_q <= 1'b1;
      rdy_q <= 1'b1;
    end else if (wr && paddr == ADDR_STAT) begin
      if (!pwdata[S_DONE]) done_q <= 1'b0;
      if (!pwdata[S_RDY]) rdy_q <= 1'b0;
    end
  end

  // stored acknowledge; in receive mode it is also the ack the master returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rack_q <= 1'b0;
    end else if (sample && ack_slot && !rx_q) begin
      rack_q <= lm_if.sda_s; // high means no acknowledge
    end else if (wr && paddr == ADDR_CTRL && !pwdata[C_ACK_CHECK_ENABLE]) begin
      rack_q <= 1'b0;
    end else if (wr && paddr == ADDR_STAT) begin
      rack_q <= pwdata[S_ACK];
    end
  end

  // transmit-empty status flag and bus-busy status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_q <= 1'b0;
      bbusy_q <= 1'b0;
    end else begin
      if (lm_if.start_det || (frame_go && ctrl_q[C_TRS])) empty_q <= 1'b1;
      else if ((wr && paddr == ADDR_DATA) || lm_if.stop_det) empty_q <= 1'b0;
      if (lm_if.start_det) bbusy_q <= 1'b1;
      else if (lm_if.stop_det) bbusy_q <= 1'b0;
    end
  end

  // bus sequencer: four quarters per scl bit, scl released in quarters 2 and 3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      bits_left_q <= 4'h0;
      shift_q <= 8'h00;
      first_q <= 1'b0;
      with_ack_q <= 1'b0;
      rx_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          scl_low_q <= 1'b0;
          sda_low_q <= 1'b0;
          if (tick && start_pend_q) begin
            st_q <= ST_START;
            ph_q <= 2'h0;
          end
        end
        ST_START: begin
          if (tick) begin
            if (ph_q == 2'h0) begin
              sda_low_q <= 1'b1; // sda falls, scl still released
              ph_q <= 2'h1;
            end else begin
              scl_low_q <= 1'b1;
              first_q <= 1'b1;
              st_q <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // scl stays low here until software supplies work
          if (tick && stop_pend_q) begin
            st_q <= ST_STOP;
            ph_q <= 2'h0;
          end else if (frame_go) begin
            st_q <= ST_BIT;
            ph_q <= 2'h0;
            shift_q <= ctrl_q[C_TRS] ? hold_q : 8'h00;
            rx_q <= !ctrl_q[C_TRS];
            with_ack_q <= !fmt_serial;
            first_q <= 1'b0;
            if (first_q && !fmt_serial) bits_left_q <= FIRST_FRAME_BITS; // address plus direction
            else bits_left_q <= bc + {3'h0, !fmt_serial};
          end
        end
        ST_BIT: begin
          case (ph_q)
            2'h0: begin
              if (tick) begin
                // receiver drives the ack slot; master acks only when receiving
                if (ack_slot) sda_low_q <= rx_q & !rack_q;
                else sda_low_q <= !rx_q & !out_bit;
                ph_q <= 2'h1;
              end
            end
            2'h1: begin
              if (tick) begin
                scl_low_q <= 1'b0;
                ph_q <= 2'h2;
              end
            end
            2'h2: begin
              // waits for scl to read high, so a stretching slave is honoured
              if (sample) begin
                ph_q <= 2'h3;
                if (rx_q && !ack_slot) begin
                  shift_q <= mode_q[M_ORDER] ? {lm_if.sda_s, shift_q[7:1]} : {shift_q[6:0], lm_if.sda_s};
                end
              end
            end
            default: begin
              if (tick) begin
                scl_low_q <= 1'b1;
                bits_left_q <= bits_left_q - 4'h1;
                if (!rx_q && !ack_slot) begin
                  shift_q <= mode_q[M_ORDER] ? {1'b0, shift_q[7:1]} : {shift_q[6:0], 1'b0};
                end
                if (last) begin
                  sda_low_q <= 1'b0;
                  st_q <= ST_HOLD;
                end else begin
                  ph_q <= 2'h0;
                end
              end
            end
          endcase
        end
        ST_STOP: begin
          if (tick && ph_q == 2'h0) begin
            sda_low_q <= 1'b1;
            ph_q <= 2'h1;
          end else if (tick && ph_q == 2'h1) begin
            scl_low_q <= 1'b0;
            ph_q <= 2'h2;
          end else if (tick && lm_if.scl_s) begin
            sda_low_q <= 1'b0; // sda rises while scl high
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_sda_first: assert property ($rose(sda_low_q) && $past(st_q) == ST_START |-> !scl_low_q)
    else $error("start: sda fell with scl low");
  chk_stop_sda_rise: assert property ($fell(sda_low_q) && $past(st_q) == ST_STOP |-> !scl_low_q && st_q == ST_IDLE)
    else $error("stop: sda rose with scl low");
  chk_done_ninth: assert property (sample && last |=> done_q && st_q == ST_BIT ##[1:300] st_q == ST_HOLD)
    else $error("done flag not set at last rising edge");
  chk_hold_scl_low: assert property (st_q == ST_HOLD |-> scl_low_q)
    else $error("scl released while holding");
  chk_first_nine: assert property (frame_go && first_q && !fmt_serial |=> bits_left_q == 4'h9 && with_ack_q)
    else $error("first addressed frame not nine bits");
  chk_serial_no_ack: assert property (frame_go && fmt_serial |=> !with_ack_q && bits_left_q == $past(bc))
    else $error("serial frame got ack slot");
  chk_start_flags: assert property (start_gen |=> done_q && rdy_q && sda_low_q)
    else $error("start did not set flags");
  chk_ack_clear: assert property (wr && paddr == ADDR_CTRL && !pwdata[C_ACK_CHECK_ENABLE] && !sample |=> !rack_q)
    else $error("ack-check disable did not clear ack");
  chk_busy_track: assert property (lm_if.start_det |=> bbusy_q)
    else $error("bus busy not set on start");
  chk_start_req: assert property (st_q == ST_IDLE && start_pend_q && tick |=> st_q == ST_START)
    else $error("start request not taken");

  cov_start: cover property (start_gen);
  cov_nack: cover property (sample && ack_slot && !rx_q && lm_if.sda_s);
  cov_rx_frame: cover property (frame_go && !ctrl_q[C_TRS]);
  cov_stop: cover property ($past(st_q) == ST_STOP && st_q == ST_IDLE);
endmodule
`default_nettype wire

// File: verification/wire_slave_model.sv
// behavioural slave on the two bus wires: acknowledges, stretches, logs bits
`timescale 1ns/1ps
`default_nettype none
module wire_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] ack_at,
  input wire logic stretch,
  output var logic scl_oe,
  output var logic sda_oe,
  output var logic [7:0] nbits,
  output var logic [63:0] bits,
  output var int starts,
  output var int stops
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    nbits = 8'h00;
    bits = 64'h0;
    starts = 0;
    stops = 0;
  end
  // a start restarts the bit count of the transfer
  // the lines settling from unknown at time zero are not bus conditions
  always @(negedge sda) begin
    if (scl === 1'b1 && $time > 0) begin
      starts++;
      nbits = 8'h00;
    end
  end
  // a stop is only counted here; the bench judges it
  always @(posedge sda) begin
    if (scl === 1'b1 && $time > 0) stops++;
  end
  // this slave samples on the clock's rising edge
  always @(posedge scl) begin
    bits = {bits[62:0], sda};
    nbits++;
  end
  // ack slot: pull data low only while the acknowledge bit is on the wire
  always @(negedge scl) begin
    sda_oe <= (nbits == ack_at);
    if (stretch) begin
      scl_oe <= 1'b1;
      #7000 scl_oe <= 1'b0; // slow answer: holds the clock past the master's release
    end
  end
endmodule
`default_nettype wire

// File: verification/i2c_master_transmit_sequencer_bench.sv
// self-checking bench: apb master, read scoreboard queue, wire-level slave
`timescale 1ns/1ps
`default_nettype none
module i2c_master_transmit_sequencer_bench import i2c_seq_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req;
  logic [7:0] paddr, ack_at, nbits, d1, d2;
  logic [31:0] pwdata, prdata, seed;
  logic scl_o, scl_oe, sda_o, sda_oe, p_scl_oe, p_sda_oe, stretch;
  logic [63:0] bits;
  logic [32:0] exp_q[$];
  int starts, stops, err_count, check_count;
  wire logic scl_w;
  wire logic sda_w;
  // open-drain wires: low if any party pulls, else the pull-up wins
  assign scl_w = (scl_oe ? scl_o : 1'b1) & ~p_scl_oe;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~p_sda_oe;

  i2c_master_transmit_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .irq_req(irq_req));
  wire_slave_model slave (.scl(scl_w), .sda(sda_w), .ack_at(ack_at), .stretch(stretch), .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe), .nbits(nbits), .bits(bits), .starts(starts), .stops(stops));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer; an idle edge after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    exp_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask
  // irq is done and enable, so it marks each finished step; the extra edges let
  // the synchronised start/stop detection reach the empty and busy flags
  task automatic wait_irq;
    int n;
    for (n = 0; n < 40000 && irq_req !== 1'b1; n++) @(posedge pclk);
    if (irq_req !== 1'b1) begin
      err_count++;
      results();
    end
    repeat (6) @(posedge pclk);
  endtask
  // the extra edges let the synchronised busy status settle
  task automatic wait_stops(input int k);
    int n;
    for (n = 0; n < 40000 && stops != k; n++) @(posedge pclk);
    if (stops != k) begin
      err_count++;
      results();
    end
    repeat (8) @(posedge pclk);
  endtask

  // scoreboard: each completed read is matched with the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk("unexpected_read", 33'h0, 33'h1FFFFFFFF);
      else chk("apb_read", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack_at = 8'h08;
    stretch = 1'b0;
    seed = xs(32'h10B6);
    d1 = {seed[7:1], 1'b0};
    seed = xs(seed);
    d2 = seed[7:0];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, an unmapped place, bus free
    rd(ADDR_CTRL, {24'h0, CTRL_RST}, 1'b0);
    rd(ADDR_MODE, {24'h0, MODE_RST}, 1'b0);
    rd(ADDR_STAT, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    // master transmit with a start, irq and ack checking on
    wr(ADDR_CTRL, 32'h37);
    wait_irq();
    rd(ADDR_STAT, 32'h0B, 1'b0);
    rd(ADDR_CTRL, 32'h37, 1'b0);
    chk("starts", 33'd1, 33'(starts));
    // address frame, write direction, slave stretching the clock
    stretch <= 1'b1;
    wr(ADDR_DATA, {24'h0, d1});
    wr(ADDR_STAT, 32'h0);
    wait_irq();
    chk("frame1_bits", 33'd9, 33'(nbits));
    chk("frame1_data", {24'h0, d1, 1'b0}, 33'(bits[8:0]));
    rd(ADDR_STAT, 32'h0B, 1'b0);
    // lsb-first full byte, slave refuses it
    stretch <= 1'b0;
    ack_at <= 8'hFF;
    wr(ADDR_MODE, 32'h08);
    wr(ADDR_DATA, {24'h0, d2});
    wr(ADDR_STAT, 32'h0);
    wait_irq();
    chk("frame2_data", {24'h0, rev8(d2), 1'b1}, 33'(bits[8:0]));
    chk("frame2_bits", 33'd18, 33'(nbits));
    rd(ADDR_STAT, 32'h0F, 1'b0);
    // stop with ack check off clears the stored ack
    wr(ADDR_CTRL, 32'h13);
    wait_stops(1);
    chk("stops", 33'd1, 33'(stops));
    rd(ADDR_STAT, 32'h03, 1'b0);
    rd(ADDR_CTRL, 32'h13, 1'b0);
    // serial format, three bits msb first, no ack slot
    wr(ADDR_MODE, 32'h13);
    rd(ADDR_MODE, 32'h13, 1'b0);
    wr(ADDR_STAT, 32'h0);
    wr(ADDR_CTRL, 32'h17);
    wait_irq();
    chk("starts", 33'd2, 33'(starts));
    wr(ADDR_DATA, 32'hA0);
    wr(ADDR_STAT, 32'h0);
    wait_irq();
    chk("serial_bits", 33'd3, 33'(nbits));
    chk("serial_data", 33'h5, 33'(bits[2:0]));
    wr(ADDR_CTRL, 32'h13);
    wait_stops(2);
    chk("stops", 33'd2, 33'(stops));
    results();
  end
endmodule
`default_nettype wire
